// ===== rcr_consts.vh
// constants for the radio configuration register bank
`ifndef RCR_CONSTS_VH
`define RCR_CONSTS_VH
`define RCR_ADDR_CFG 5'h00
`define RCR_ADDR_AA 5'h01
`define RCR_ADDR_RXEN 5'h02
`define RCR_ADDR_AW 5'h03
`define RCR_ADDR_RETR 5'h04
`define RCR_ADDR_CH 5'h05
`define RCR_ADDR_RF 5'h06
`define RCR_ADDR_STATUS 5'h07
`define RCR_ADDR_FIFO 5'h17
`define RCR_ADDR_FEAT 5'h1D
`define RCR_RST_CFG 8'h08
`define RCR_RST_AA 8'h3F
`define RCR_RST_RXEN 8'h3F
`define RCR_RST_AW 8'h0F
`define RCR_RST_RETR 8'h03
`define RCR_RST_CH 8'h02
`define RCR_RST_RF 8'h02
`define RCR_RST_FEAT 8'h00
`define RCR_MASK_CFG 8'h7F
`define RCR_MASK_PIPES 8'h3F
`define RCR_MASK_AW 8'h0F
`define RCR_MASK_CH 8'h7F
`define RCR_MASK_RF 8'hFE
`define RCR_MASK_FEAT 8'h03
`define RCR_CMD_RREG 3'b000
`define RCR_CMD_WREG 3'b001
`define RCR_BIT_RXM 6
`define RCR_BIT_TXM 5
`define RCR_BIT_RTM 4
`define RCR_BIT_CRC 3
`define RCR_RO_STATUS 2'h0
`define RCR_RO_RX 2'h1
`define RCR_RO_FIFO 2'h2
`define RCR_DLY_BASE_CYC 19'h061A8
`define RCR_DLY_STEP_CYC 19'h061A8
`define RCR_FREQ_BASE_MHZ 12'h960
`define RCR_BITS_LAST 3'h7
`endif

// ===== rcr_regs.v
// spi slave and configuration register bank of the radio
`include "rcr_consts.vh"
////////////////////////////////////////////////////////////////////////////////
module rcr_regs (
  input wire clk,
  input wire reset_n,
  input wire spi_csn,
  input wire spi_sck,
  input wire spi_mosi,
  output reg spi_miso,
  output reg spi_miso_oe,
  output reg irq_n,
  input wire rx_ready_set,
  input wire tx_sent_set,
  input wire retransmit_limit_set,
  input wire [2:0] rx_pipe_number,
  input wire tx_fifo_full,
  input wire signal_threshold_one,
  input wire signal_threshold_two,
  input wire [7:0] fifo_status,
  output wire rx_ready_irq_mask,
  output wire tx_sent_irq_mask,
  output wire retransmit_limit_irq_mask,
  output wire crc_enable,
  output wire checksum_length_select,
  output wire power_up_bit,
  output wire primary_receiver_role,
  output wire [5:0] auto_ack_pipe_enable,
  output wire [5:0] receive_pipe_enable,
  output wire [3:0] retransmit_delay_field,
  output wire [3:0] retransmit_count,
  output wire [18:0] retransmit_delay_cycles,
  output wire [6:0] radio_channel,
  output wire [11:0] carrier_mhz,
  output wire [7:0] radio_settings
);
  localparam [18:0] DLY_BASE = `RCR_DLY_BASE_CYC;
  localparam [18:0] DLY_STEP = `RCR_DLY_STEP_CYC;
  localparam [11:0] FREQ_BASE = `RCR_FREQ_BASE_MHZ;
  localparam [3:0] ST_CMD = 4'b0001;
  localparam [3:0] ST_DATA = 4'b0010;
  localparam [3:0] ST_SKIP = 4'b0100;
  localparam [3:0] ST_IDLE = 4'b1000;
  reg [2:0] csn_sync_reg, sck_sync_reg, mosi_sync_reg;
  reg [3:0] state_reg, state_next;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shin_reg, shout_reg;
  reg [4:0] addr_reg;
  reg is_write_reg;
  reg [7:0] cfg_reg, aa_reg, rxen_reg, aw_reg, retr_reg, ch_reg, rf_reg, feat_reg;
  reg [2:0] flags_reg;
  reg wr_pulse;
  reg [7:0] wr_byte;
  reg [7:0] rd_byte;
  reg [7:0] status_byte;
  wire csn_s = csn_sync_reg[1];
  wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  wire csn_fall = ~csn_sync_reg[1] & csn_sync_reg[2];
  wire [7:0] shin_full = {shin_reg[6:0], mosi_sync_reg[1]};
  wire byte_done = sck_rise & (bit_cnt_reg == `RCR_BITS_LAST) & ~csn_s;
  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      csn_sync_reg <= 3'h7;
      sck_sync_reg <= 3'h0;
      mosi_sync_reg <= 3'h0;
    end else begin
      csn_sync_reg <= {csn_sync_reg[1:0], spi_csn};
      sck_sync_reg <= {sck_sync_reg[1:0], spi_sck};
      mosi_sync_reg <= {mosi_sync_reg[1:0], spi_mosi};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // status byte variants
  always @* begin
    status_byte = {1'b0, flags_reg, rx_pipe_number, tx_fifo_full};
    case (feat_reg[1:0])
      `RCR_RO_RX: status_byte = {1'b0, flags_reg[2:1], signal_threshold_two,
                                 rx_pipe_number, signal_threshold_one};
      `RCR_RO_FIFO: status_byte = fifo_status;
      default: status_byte = {1'b0, flags_reg, rx_pipe_number, tx_fifo_full};
    endcase
  end
  // read mux on the address just shifted in; unmapped and test addresses read zero
  always @* begin
    case (shin_full[4:0])
      `RCR_ADDR_CFG: rd_byte = cfg_reg;
      `RCR_ADDR_AA: rd_byte = aa_reg;
      `RCR_ADDR_RXEN: rd_byte = rxen_reg;
      `RCR_ADDR_AW: rd_byte = aw_reg;
      `RCR_ADDR_RETR: rd_byte = retr_reg;
      `RCR_ADDR_CH: rd_byte = ch_reg;
      `RCR_ADDR_RF: rd_byte = rf_reg;
      `RCR_ADDR_STATUS: rd_byte = {1'b0, flags_reg, rx_pipe_number, tx_fifo_full};
      `RCR_ADDR_FIFO: rd_byte = fifo_status;
      `RCR_ADDR_FEAT: rd_byte = feat_reg;
      default: rd_byte = 8'h00;
    endcase
  end
  ////////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always @* begin
    state_next = state_reg;
    wr_pulse = 1'b0;
    wr_byte = shin_full;
    case (state_reg)
      ST_IDLE: if (csn_fall) state_next = ST_CMD;
      ST_CMD: if (byte_done) begin
        if (shin_full[7:5] == `RCR_CMD_RREG || shin_full[7:5] == `RCR_CMD_WREG) begin
          state_next = ST_DATA;
        end else begin
          state_next = ST_SKIP;
        end
      end
      ST_DATA: if (byte_done) begin
        wr_pulse = is_write_reg;
        state_next = ST_SKIP;
      end
      ST_SKIP: state_next = ST_SKIP;
      default: state_next = ST_IDLE;
    endcase
    if (csn_s) state_next = ST_IDLE;
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shin_reg <= 8'h00;
      shout_reg <= 8'h00;
      addr_reg <= 5'h00;
      is_write_reg <= 1'b0;
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      state_reg <= state_next;
      spi_miso_oe <= ~csn_s;
      if (csn_fall) begin
        bit_cnt_reg <= 3'h0;
        shout_reg <= {status_byte[6:0], 1'b0};
        spi_miso <= status_byte[7];
      end else if (sck_rise && !csn_s) begin
        shin_reg <= shin_full;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (state_reg == ST_CMD && bit_cnt_reg == `RCR_BITS_LAST) begin
          addr_reg <= shin_full[4:0];
          is_write_reg <= (shin_full[7:5] == `RCR_CMD_WREG);
          shout_reg <= (shin_full[7:5] == `RCR_CMD_RREG) ? rd_byte : 8'h00;
        end
      end else if (sck_fall && !csn_s) begin
        spi_miso <= shout_reg[7];
        shout_reg <= {shout_reg[6:0], 1'b0};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // register file
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= `RCR_RST_CFG;
      aa_reg <= `RCR_RST_AA;
      rxen_reg <= `RCR_RST_RXEN;
      aw_reg <= `RCR_RST_AW;
      retr_reg <= `RCR_RST_RETR;
      ch_reg <= `RCR_RST_CH;
      rf_reg <= `RCR_RST_RF;
      feat_reg <= `RCR_RST_FEAT;
    end else if (wr_pulse) begin
      case (addr_reg)
        `RCR_ADDR_CFG: cfg_reg <= wr_byte & `RCR_MASK_CFG;
        `RCR_ADDR_AA: aa_reg <= wr_byte & `RCR_MASK_PIPES;
        `RCR_ADDR_RXEN: rxen_reg <= wr_byte & `RCR_MASK_PIPES;
        `RCR_ADDR_AW: aw_reg <= wr_byte & `RCR_MASK_AW;
        `RCR_ADDR_RETR: retr_reg <= wr_byte;
        `RCR_ADDR_CH: ch_reg <= wr_byte & `RCR_MASK_CH;
        `RCR_ADDR_RF: rf_reg <= wr_byte & `RCR_MASK_RF;
        `RCR_ADDR_FEAT: feat_reg <= wr_byte & `RCR_MASK_FEAT;
        default: feat_reg <= feat_reg;
      endcase
    end
  end
  // interrupt flags: set wins over write-one clear
  wire clr_hit = wr_pulse & (addr_reg == `RCR_ADDR_STATUS);
  wire [2:0] flag_set = {rx_ready_set, tx_sent_set, retransmit_limit_set};
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_reg <= 3'h0;
      irq_n <= 1'b1;
    end else begin
      flags_reg <= (flags_reg & ~(clr_hit ? wr_byte[6:4] : 3'h0)) | flag_set;
      irq_n <= ~|(flags_reg & ~cfg_reg[`RCR_BIT_RXM:`RCR_BIT_RTM]);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // decoded outputs
  assign rx_ready_irq_mask = cfg_reg[`RCR_BIT_RXM];
  assign tx_sent_irq_mask = cfg_reg[`RCR_BIT_TXM];
  assign retransmit_limit_irq_mask = cfg_reg[`RCR_BIT_RTM];
  assign crc_enable = cfg_reg[`RCR_BIT_CRC] | (|aa_reg[5:0]);
  assign checksum_length_select = cfg_reg[2];
  assign power_up_bit = cfg_reg[1];
  assign primary_receiver_role = cfg_reg[0];
  assign auto_ack_pipe_enable = aa_reg[5:0];
  assign receive_pipe_enable = rxen_reg[5:0];
  assign retransmit_delay_field = retr_reg[7:4];
  assign retransmit_count = retr_reg[3:0];
  assign retransmit_delay_cycles = DLY_BASE + DLY_STEP * {15'h0000, retr_reg[7:4]};
  assign radio_channel = ch_reg[6:0];
  assign carrier_mhz = FREQ_BASE + {5'h00, ch_reg[6:0]};
  assign radio_settings = rf_reg;
endmodule // rcr_regs

// ===== rcr_regs_monitor.sv
// assertion checker of the register bank ports
module rcr_regs_monitor (
  input wire clk,
  input wire reset_n,
  input wire spi_csn,
  input wire spi_miso_oe,
  input wire irq_n,
  input wire rx_ready_set,
  input wire rx_ready_irq_mask,
  input wire tx_sent_irq_mask,
  input wire retransmit_limit_irq_mask,
  input wire crc_enable,
  input wire checksum_length_select,
  input wire power_up_bit,
  input wire primary_receiver_role,
  input wire [5:0] auto_ack_pipe_enable,
  input wire [5:0] receive_pipe_enable,
  input wire [3:0] retransmit_delay_field,
  input wire [3:0] retransmit_count,
  input wire [6:0] radio_channel,
  input wire [11:0] carrier_mhz
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_crc; (|auto_ack_pipe_enable) |-> crc_enable; endproperty
  a_crc: assert property (p_crc) else $error("crc off");
  property p_rcfg; $rose(reset_n) |-> !checksum_length_select && !power_up_bit; endproperty
  a_rcfg: assert property (p_rcfg) else $error("cfg reset");
  property p_rrole; $rose(reset_n) |-> !primary_receiver_role && crc_enable; endproperty
  a_rrole: assert property (p_rrole) else $error("role reset");
  property p_pipes; $rose(reset_n) |-> (auto_ack_pipe_enable & receive_pipe_enable) == 6'h3F;
  endproperty
  a_pipes: assert property (p_pipes) else $error("pipe reset");
  property p_retr; $rose(reset_n) |-> {retransmit_delay_field, retransmit_count} == 8'h03;
  endproperty
  a_retr: assert property (p_retr) else $error("retr reset");
  property p_carr; carrier_mhz == 12'h960 + {5'h00, radio_channel}; endproperty
  a_carr: assert property (p_carr) else $error("carrier");
  property p_irq; rx_ready_set && !rx_ready_irq_mask |-> ##[1:3] !irq_n; endproperty
  a_irq: assert property (p_irq) else $error("irq low");
  property p_msk;
    (rx_ready_irq_mask && tx_sent_irq_mask && retransmit_limit_irq_mask) [*3] |-> irq_n;
  endproperty
  a_msk: assert property (p_msk) else $error("irq masked");
  property p_oe; $fell(spi_csn) |-> ##[2:5] spi_miso_oe; endproperty
  a_oe: assert property (p_oe) else $error("miso oe");
endmodule // rcr_regs_monitor
////////////////////////////////////////////////////////////////////////////////
bind rcr_regs rcr_regs_monitor u_rcr_regs_monitor (.clk, .reset_n, .spi_csn, .spi_miso_oe,
  .irq_n, .rx_ready_set, .rx_ready_irq_mask, .tx_sent_irq_mask, .retransmit_limit_irq_mask,
  .crc_enable, .checksum_length_select, .power_up_bit, .primary_receiver_role,
  .auto_ack_pipe_enable, .receive_pipe_enable, .retransmit_delay_field, .retransmit_count,
  .radio_channel, .carrier_mhz);

// ===== rcr_host.sv
// spi master model of the host controller
module rcr_host (
  output logic spi_csn,
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_csn = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
  // command byte then data byte, mode 0, msb first; sck idle low
  task automatic xfer(input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] st, output logic [7:0] rd);
    logic [15:0] tx;
    logic [15:0] rx;
    tx = {c, d};
    spi_csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = tx[i];
      #62.5;
      rx[i] = spi_miso_oe ? spi_miso : 1'bx;
      spi_sck = 1'b1;
      #62.5;
      spi_sck = 1'b0;
    end
    #62.5;
    spi_csn = 1'b1;
    spi_mosi = ~tx[0];
    #125;
    st = rx[15:8];
    rd = rx[7:0];
  endtask
endmodule // rcr_host

// ===== rcr_regs_bench.sv
// self-checking bench of the register bank
module rcr_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [2:0] sets = 3'h0;
  wire spi_csn, spi_sck, spi_mosi, spi_miso, spi_miso_oe, irq_n, crc_enable;
  wire [11:0] carrier_mhz;
  wire [18:0] dly;
  logic [7:0] st, rd;
  int fail_count = 0;
  int comparisons = 0;
  // address, write value, reset value, readback
  logic [31:0] rows [10] = '{32'h007F087F, 32'h01FF3F3F, 32'h02FF3F3F, 32'h03FF0F0F,
    32'h04FF03FF, 32'h05FF027F, 32'h06FF02FE, 32'h19000000, 32'h1A000000, 32'h1F000000};
  logic [7:0] modes [4] = '{8'h0B, 8'h1A, 8'hA5, 8'h0B};
  always #5 clk = ~clk;
  rcr_host u_rcr_host (.spi_csn, .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe);
  rcr_regs u_rcr_regs (.clk, .reset_n, .spi_csn, .spi_sck, .spi_mosi, .spi_miso,
    .spi_miso_oe, .irq_n, .rx_ready_set(sets[2]), .tx_sent_set(sets[1]),
    .retransmit_limit_set(sets[0]), .rx_pipe_number(3'h5), .tx_fifo_full(1'b1),
    .signal_threshold_one(1'b0), .signal_threshold_two(1'b1), .fifo_status(8'hA5),
    .rx_ready_irq_mask(), .tx_sent_irq_mask(), .retransmit_limit_irq_mask(), .crc_enable,
    .checksum_length_select(), .power_up_bit(), .primary_receiver_role(),
    .auto_ack_pipe_enable(), .receive_pipe_enable(), .retransmit_delay_field(),
    .retransmit_count(), .retransmit_delay_cycles(dly), .radio_channel(), .carrier_mhz,
    .radio_settings());
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_rcr_host.xfer({3'b001, a[4:0]}, d, st, rd);
  endtask
  task automatic rdr(input logic [7:0] a);
    u_rcr_host.xfer({3'b000, a[4:0]}, 8'h00, st, rd);
  endtask
  task automatic pulse_irq(input int b);
    @(negedge clk) sets[b] = 1'b1;
    @(negedge clk) sets = 3'h0;
  endtask
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 8 && irq_n !== lvl; i++) @(negedge clk);
    check("irq_n", {11'h0, irq_n}, {11'h0, lvl});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400us;
    fail_count++;
    close_out();
  end
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      rdr(rows[i][31:24]);
      check("reset", {4'h0, rd}, {4'h0, rows[i][15:8]});
      wr(rows[i][31:24], rows[i][23:16]);
      rdr(rows[i][31:24]);
      check("readback", {4'h0, rd}, {4'h0, rows[i][7:0]});
    end
    check("carrier", carrier_mhz, 12'h9DF);
    check("delay", {1'h0, dly}, 20'h61A80);
    for (int b = 4; b < 7; b++) begin
      wr(8'h00, 8'h08);
      pulse_irq(b - 4);
      wait_irq(1'b0);
      rdr(8'h07);
      check("flag", {4'h0, st}, 12'h00B | (12'h001 << b));
      wr(8'h07, 8'h01 << b);
      wait_irq(1'b1);
      wr(8'h00, 8'h08 | (8'h01 << b));
      pulse_irq(b - 4);
      repeat (4) @(negedge clk);
      wait_irq(1'b1);
      wr(8'h07, 8'h01 << b);
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h1D, m[7:0]);
      rdr(8'h00);
      check("readout", {4'h0, st}, {4'h0, modes[m]});
    end
    wr(8'h01, 8'h00);
    wr(8'h00, 8'h00);
    check("crc", {11'h0, crc_enable}, 12'h000);
    wr(8'h01, 8'h01);
    check("crc", {11'h0, crc_enable}, 12'h001);
    @(negedge clk) reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    rdr(8'h05);
    check("channel", {4'h0, rd}, 12'h002);
    close_out();
  end
endmodule // rcr_regs_bench
